// File: hdl/flash_spi_regs.vh
// Purpose: Constants for the serial flash command interface
// Assumes: Included by flash_spi_slave.v and by the assertion and bench files
// Notes:   Opcodes, header lengths and page geometry
`ifndef FLASH_SPI_REGS_VH
`define FLASH_SPI_REGS_VH

// ----------------------------------------------------------------
// Read opcodes
// ----------------------------------------------------------------
`define OPC_CARD_LEGACY  8'he8
`define OPC_CARD_FAST    8'h0b
`define OPC_CARD_SLOW    8'h03
`define OPC_PAGE_READ    8'hd2
`define OPC_BUF_READ     8'hd4
`define OPC_PROT_READ    8'h32
`define OPC_LOCK_READ    8'h35
`define OPC_SEC_READ     8'h77
`define OPC_STATUS_READ  8'hd7
`define OPC_ID_READ      8'h9f

// ----------------------------------------------------------------
// Header lengths in bytes after the opcode
// ----------------------------------------------------------------
`define ADDR_BYTES       3'd3
`define DUMMY_LEGACY     3'd4
`define DUMMY_FAST       3'd1
`define DUMMY_NONE       3'd0
`define DUMMY_PAGE       3'd4
`define DUMMY_BUF        3'd1
`define DUMMY_REG        3'd3

// ----------------------------------------------------------------
// Page geometry
// ----------------------------------------------------------------
`define PAGE_LAST_256    9'h0ff
`define PAGE_LAST_264    9'h107
`define ID_BYTES         2'd3

`endif

// File: hdl/flash_spi_slave.v
// Purpose: Device side of the serial flash command interface
// Assumes: Serial clock well below i_clk/4; memory array lives outside
// Notes:   SCK, CS, SI and the reset pin are sampled by i_clk
//
// Functional notes
// RULE1: Sample SI on serial clock rising edges, change SO only on falling edges.
// RULE2: Host launches its bits on rising edges, giving a full period of setup.
// RULE3: Host should capture SO on the next falling edge for full-cycle speed.
// RULE4: Transactions accepted with serial clock idling low or high at select fall.
// RULE5: Every SO bit becomes valid while the serial clock is still low.
// RULE6: In high-speed style the host relies on full-cycle sampling of SO.
// RULE7: Host keeps select high before releasing the reset pin.
// RULE8: Decode E8H, 0BH and 03H as continuous reads through the whole array.
// RULE9: Decode D2H as main page read and D4H as buffer read.
// RULE10: Decode 32H, 35H and 77H as protection, lockdown and security reads.
// RULE11: Decode D7H as status read and 9FH as identification read.
// RULE12: Address framing follows 256 or 264 byte pages; status and ID exempt.
// RULE13: A page is programmed directly or via buffer load then buffer program.
// RULE14: Host rewrites every sector page within 10,000 erase/program operations.
// RULE15: Host keeps a rewrite pointer and rewrites the page it names.
// RULE16: Bytes go MSB first; a command starts at first rising edge after select.
`timescale 1ns/1ps
`default_nettype none
`include "flash_spi_regs.vh"

module flash_spi_slave #(
  parameter [7:0] ID_MFR      = 8'h5a, // Arbitrary value
  parameter [7:0] ID_DEV0     = 8'h01, // Arbitrary value
  parameter [7:0] ID_DEV1     = 8'h02, // Arbitrary value
  parameter [7:0] ID_EXT      = 8'h00, // Arbitrary value
  parameter [7:0] OPC_BUF_WR  = 8'h84,
  parameter [7:0] OPC_BUF_PGM = 8'h83,
  parameter [7:0] OPC_PAGE_PGM = 8'h82
) (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_cs_n,
  input  wire       i_sck,
  input  wire       i_si,
  input  wire       i_reset_pin_n,
  output reg        o_so,
  output reg        o_so_oe_n,
  input  wire       i_page_256,
  input  wire [7:0] i_status,
  input  wire [7:0] i_rd_data,
  output reg        o_rd_req,
  output reg  [7:0] o_rd_opc,
  output reg  [8:0] o_rd_page,
  output reg  [8:0] o_rd_off,
  output reg        o_wr_stb,
  output reg  [7:0] o_wr_data,
  output reg  [8:0] o_wr_page,
  output reg  [8:0] o_wr_off,
  output reg        o_prog_req,
  output reg  [7:0] o_prog_opc
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_OPC  = 7'h02;
  localparam [6:0] S_ADDR = 7'h04;
  localparam [6:0] S_DUMY = 7'h08;
  localparam [6:0] S_DOUT = 7'h10;
  localparam [6:0] S_DIN  = 7'h20;
  localparam [6:0] S_SKIP = 7'h40;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg cs_s1_q, cs_s2_q, cs_s3_q;
  reg sck_s1_q, sck_s2_q, sck_s3_q;
  reg si_s1_q, si_s2_q, si_s3_q;
  reg rp_s1_q, rp_s2_q;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      si_s1_q  <= 1'b0;
      si_s2_q  <= 1'b0;
      si_s3_q  <= 1'b0;
      rp_s1_q  <= 1'b0;
      rp_s2_q  <= 1'b0;
    end
    else
    begin
      cs_s1_q  <= i_cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      sck_s1_q <= i_sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q  <= i_si;
      si_s2_q  <= si_s1_q;
      si_s3_q  <= si_s2_q;
      rp_s1_q  <= i_reset_pin_n;
      rp_s2_q  <= rp_s1_q;
    end
  end

  // Edges count only while selected, so a mode 3 idle-high clock at the
  // select fall produces no spurious edge
  wire active    = ~cs_s2_q & ~cs_s3_q & rp_s2_q; // RULE4 RULE7
  wire sck_rise  = active & sck_s2_q & ~sck_s3_q;
  wire sck_fall  = active & ~sck_s2_q & sck_s3_q;
  wire cs_rise   = cs_s2_q & ~cs_s3_q;

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  reg [6:0] state_q;
  reg [2:0] bit_q;
  reg [6:0] sh_in_q;
  reg [7:0] opc_q;
  reg [2:0] addr_left_q;
  reg [2:0] dummy_q;
  reg [15:0] addr_q;
  reg [8:0] page_q;
  reg [8:0] off_q;
  reg [1:0] id_idx_q;
  reg       wrote_q;

  // SI is taken one sample before the seen rise: a host launching on the rise gets a full period
  wire [7:0]  in_byte  = {sh_in_q, si_s3_q};                   // RULE1 RULE16
  wire        byte_end = sck_rise & (bit_q == 3'd7);
  wire [23:0] full_adr = {addr_q, in_byte};
  wire [8:0]  page_last = i_page_256 ? `PAGE_LAST_256 : `PAGE_LAST_264;
  wire [8:0]  adr_page = i_page_256 ? full_adr[16:8] : full_adr[17:9]; // RULE12
  wire [8:0]  adr_off  = i_page_256 ? {1'b0, full_adr[7:0]} : full_adr[8:0]; // RULE12
  wire        is_cont  = (opc_q == `OPC_CARD_LEGACY) | (opc_q == `OPC_CARD_FAST) |
                         (opc_q == `OPC_CARD_SLOW);
  wire        is_write = (opc_q == OPC_BUF_WR) | (opc_q == OPC_PAGE_PGM);
  wire        off_wrap = (off_q == page_last);
  wire [8:0]  off_next = off_wrap ? 9'h000 : off_q + 9'h001;
  wire [8:0]  page_next = (off_wrap & is_cont) ? page_q + 9'h001 : page_q; // RULE8

  // Opcode decode: header bytes and acceptance
  reg       dec_ok;
  reg       dec_noadr;
  reg [2:0] dec_dummy;
  always @*
  begin
    dec_ok    = 1'b1;
    dec_noadr = 1'b0;
    dec_dummy = `DUMMY_NONE;
    case (in_byte)
      `OPC_CARD_LEGACY: dec_dummy = `DUMMY_LEGACY;  // RULE8
      `OPC_CARD_FAST:   dec_dummy = `DUMMY_FAST;    // RULE8
      `OPC_CARD_SLOW:   dec_dummy = `DUMMY_NONE;    // RULE8
      `OPC_PAGE_READ:   dec_dummy = `DUMMY_PAGE;    // RULE9
      `OPC_BUF_READ:    dec_dummy = `DUMMY_BUF;     // RULE9
      `OPC_PROT_READ, `OPC_LOCK_READ, `OPC_SEC_READ:
        dec_dummy = `DUMMY_NONE;                    // RULE10
      `OPC_STATUS_READ, `OPC_ID_READ:
        dec_noadr = 1'b1;                           // RULE11 RULE12
      default:
        dec_ok = (in_byte == OPC_BUF_WR) | (in_byte == OPC_PAGE_PGM) |
                 (in_byte == OPC_BUF_PGM);          // RULE13
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q     <= S_IDLE;
      bit_q       <= 3'd0;
      sh_in_q     <= 7'h00;
      opc_q       <= 8'h00;
      addr_left_q <= 3'd0;
      dummy_q     <= 3'd0;
      addr_q      <= 16'h0000;
      page_q      <= 9'h000;
      off_q       <= 9'h000;
      id_idx_q    <= 2'd0;
      wrote_q     <= 1'b0;
      o_rd_req    <= 1'b0;
      o_rd_opc    <= 8'h00;
      o_rd_page   <= 9'h000;
      o_rd_off    <= 9'h000;
      o_wr_stb    <= 1'b0;
      o_wr_data   <= 8'h00;
      o_wr_page   <= 9'h000;
      o_wr_off    <= 9'h000;
      o_prog_req  <= 1'b0;
      o_prog_opc  <= 8'h00;
    end
    else
    begin
      o_rd_req   <= 1'b0;
      o_wr_stb   <= 1'b0;
      o_prog_req <= 1'b0;
      if (!rp_s2_q | cs_s2_q)
      begin
        // A program is handed over only on a clean release, never after a pin abort
        if (cs_rise & rp_s2_q & ((wrote_q & (opc_q == OPC_PAGE_PGM)) |
            ((opc_q == OPC_BUF_PGM) & (state_q == S_DIN))))
        begin
          o_prog_req <= 1'b1;                       // RULE13
          o_prog_opc <= opc_q;
        end
        state_q <= S_IDLE;
        bit_q   <= 3'd0;
        wrote_q <= 1'b0;
      end
      else
      begin
        if (state_q == S_IDLE)
          state_q <= S_OPC;                         // RULE16
        if (sck_rise)
        begin
          sh_in_q <= in_byte[6:0];                  // RULE1
          bit_q   <= bit_q + 3'd1;
        end
        if (byte_end)
        begin
          case (state_q)
            S_OPC:
            begin
              opc_q       <= in_byte;
              addr_left_q <= `ADDR_BYTES - 3'd1;
              dummy_q     <= dec_dummy;
              id_idx_q    <= 2'd0;
              state_q     <= !dec_ok ? S_SKIP : (dec_noadr ? S_DOUT : S_ADDR); // RULE11
              if (dec_ok & dec_noadr)
                o_rd_opc <= in_byte;
            end
            S_ADDR:
            begin
              addr_q      <= full_adr[15:0];
              addr_left_q <= addr_left_q - 3'd1;
              if (addr_left_q == 3'd0)
              begin
                page_q <= adr_page;                 // RULE12
                off_q  <= adr_off;
                if (is_write | (opc_q == OPC_BUF_PGM))
                  state_q <= S_DIN;
                else if (dummy_q != 3'd0)
                  state_q <= S_DUMY;
                else
                begin
                  state_q   <= S_DOUT;
                  o_rd_req  <= 1'b1;
                  o_rd_opc  <= opc_q;
                  o_rd_page <= adr_page;
                  o_rd_off  <= adr_off;
                end
              end
            end
            S_DUMY:
            begin
              dummy_q <= dummy_q - 3'd1;
              if (dummy_q == 3'd1)
              begin
                state_q   <= S_DOUT;
                o_rd_req  <= 1'b1;
                o_rd_opc  <= opc_q;
                o_rd_page <= page_q;
                o_rd_off  <= off_q;
              end
            end
            S_DOUT:
            begin
              // Next byte is fetched half a clock ahead of its first bit;
              // status and ID bytes come from inside, so they fetch nothing
              id_idx_q  <= id_idx_q + 2'd1;
              page_q    <= page_next;               // RULE8
              off_q     <= off_next;
              o_rd_req  <= ~((opc_q == `OPC_STATUS_READ) | (opc_q == `OPC_ID_READ)); // RULE11
              o_rd_page <= page_next;
              o_rd_off  <= off_next;
            end
            S_DIN:
            begin
              if (opc_q != OPC_BUF_PGM)
              begin
                o_wr_stb  <= 1'b1;                  // RULE13
                o_wr_data <= in_byte;
                o_wr_page <= page_q;
                o_wr_off  <= off_q;
                off_q     <= off_next;
                wrote_q   <= 1'b1;
              end
            end
            default:
              state_q <= state_q;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------
  reg [6:0] sh_out_q;
  reg [2:0] obit_q;
  reg [7:0] out_byte;

  always @*
  begin
    case (opc_q)
      `OPC_STATUS_READ: out_byte = i_status;        // RULE11
      `OPC_ID_READ:
      begin
        case (id_idx_q)
          2'd0:    out_byte = ID_MFR;
          2'd1:    out_byte = ID_DEV0;
          2'd2:    out_byte = ID_DEV1;
          default: out_byte = ID_EXT;
        endcase
      end
      default:         out_byte = i_rd_data;
    endcase
  end

  // SO moves a few i_clk cycles after the sampled falling edge, well
  // inside the low phase at the bench rate; this caps the usable serial
  // rate far below the part's top rate
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_so      <= 1'b0;
      o_so_oe_n <= 1'b1;
      sh_out_q  <= 7'h00;
      obit_q    <= 3'd0;
    end
    else if ((state_q != S_DOUT) | cs_s2_q | !rp_s2_q)
    begin
      o_so_oe_n <= 1'b1;
      obit_q    <= 3'd0;
    end
    else if (sck_fall)
    begin
      o_so_oe_n <= 1'b0;                            // RULE5
      obit_q    <= obit_q + 3'd1;
      // SO then stands a full period, so the host may sample on the next fall
      o_so     <= (obit_q == 3'd0) ? out_byte[7] : sh_out_q[6];       // RULE1 RULE6 RULE16
      sh_out_q <= (obit_q == 3'd0) ? out_byte[6:0] : {sh_out_q[5:0], 1'b0};
    end
  end

endmodule
`default_nettype wire

// File: test/flash_spi_slave_asserts.sv
// Purpose: Port checks of the serial flash slave
// Assumes: One clock domain; pins sampled raw
// Notes:   Windows allow for the pin synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "flash_spi_regs.vh"
module flash_spi_slave_asserts (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_cs_n,
  input wire logic       i_sck,
  input wire logic       i_reset_pin_n,
  input wire logic       i_page_256,
  input wire logic       o_so,
  input wire logic       o_so_oe_n,
  input wire logic       o_rd_req,
  input wire logic [7:0] o_rd_opc,
  input wire logic [8:0] o_rd_off,
  input wire logic       o_prog_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic       sck_q;
  logic [3:0] fall_age_q;
  // Age saturates so a stale clock fall never looks recent
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      fall_age_q <= 4'hf;
    else if (sck_q && !i_sck)
      fall_age_q <= 4'h0;
    else if (fall_age_q != 4'hf)
      fall_age_q <= fall_age_q + 4'h1;
  end
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sck_q <= 1'b0;
    else
      sck_q <= i_sck;
  end
  sequence cs_idle_s;
    i_cs_n [*6];
  endsequence
  sequence pin_low_s;
    !i_reset_pin_n [*5];
  endsequence
  so_fall_a: assert property (
    $changed(o_so) && !o_so_oe_n |-> fall_age_q inside {[4'h1:4'h5]})
    else $error("so moved without a clock fall");
  so_low_a: assert property (
    $changed(o_so) && !o_so_oe_n |-> !i_sck)
    else $error("so moved in clock high phase");
  rd_pulse_a: assert property (
    o_rd_req |=> !o_rd_req)
    else $error("fetch pulse too long");
  rd_opc_a: assert property (
    o_rd_req |-> o_rd_opc inside {`OPC_CARD_LEGACY, `OPC_CARD_FAST, `OPC_CARD_SLOW,
      `OPC_PAGE_READ, `OPC_BUF_READ, `OPC_PROT_READ, `OPC_LOCK_READ, `OPC_SEC_READ})
    else $error("fetch for unknown opcode");
  rd_off_a: assert property (
    o_rd_req |-> o_rd_off <= (i_page_256 ? `PAGE_LAST_256 : `PAGE_LAST_264))
    else $error("offset beyond page");
  oe_idle_a: assert property (
    cs_idle_s |-> o_so_oe_n && !o_rd_req)
    else $error("active while deselected");
  pin_rel_a: assert property (
    pin_low_s |-> o_so_oe_n)
    else $error("so driven under reset pin");
  prog_cs_a: assert property (
    o_prog_req |-> i_cs_n ##1 !o_prog_req)
    else $error("program request misplaced");
endmodule
`default_nettype wire

// File: test/spi_host_model.sv
// Purpose: Host driving select, clock and data in
// Assumes: Clock period 125 ns
// Notes:   SO taken at the next falling edge, full-cycle timing
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output var logic o_cs_n,
  output var logic o_sck,
  output var logic o_si,
  input  wire logic i_so
);
  // Bits launch on the rising edge; the slave takes the value held before it
  localparam realtime HALF = 62.5;
  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
  end
  task automatic frame(input logic m3, input logic [127:0] tx, input int nb,
                       output logic [127:0] rx);
    rx = '0;
    o_sck = m3;
    o_si = tx[127];
    #(HALF) o_cs_n = 1'b0;
    #(HALF) o_sck = 1'b0;
    for (int j = 0; j < nb * 8; j++)
    begin
      #(HALF) o_sck = 1'b1;
      o_si = (j < 127) ? tx[126 - j] : ~o_si;
      #(HALF) rx = {rx[126:0], i_so};
      o_sck = (j == nb * 8 - 1) ? m3 : 1'b0;
    end
    #(HALF) o_cs_n = 1'b1;
    o_si = ~o_si;
  endtask
endmodule
`default_nettype wire

// File: test/serial_flash_spi_interface_tb.sv
// Purpose: Bench for the serial flash slave
// Assumes: Host model at 8 MHz serial clock
// Notes:   Memory side answers from a fixed pattern
`timescale 1ns/1ps
`default_nettype none
`include "flash_spi_regs.vh"
module serial_flash_spi_interface_tb;
  logic         clk, rst_n, pin_n, p256, cs_n, sck, si, so, oe_n;
  logic         rd_req, wr_stb, prog_req;
  logic [7:0]   status, rd_data, rd_opc, wr_data, prog_opc, last_opc;
  logic [8:0]   rd_page, rd_off, wr_page, wr_off;
  logic [127:0] rx;
  logic [25:0]  wr_log[$];
  int           error_cnt, n_tests, cyc, n_prog;
  localparam logic [7:0] OPCS [8] = '{`OPC_CARD_LEGACY, `OPC_CARD_FAST, `OPC_CARD_SLOW,
    `OPC_PAGE_READ, `OPC_BUF_READ, `OPC_PROT_READ, `OPC_LOCK_READ, `OPC_SEC_READ};
  localparam int DUM [8] = '{4, 1, 0, 4, 1, 0, 0, 0};
  // Identification values are arbitrary
  flash_spi_slave #(.ID_MFR(8'h3c), .ID_DEV0(8'h4d), .ID_DEV1(8'h5e), .ID_EXT(8'h6f)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .i_reset_pin_n(pin_n), .o_so(so), .o_so_oe_n(oe_n), .i_page_256(p256),
    .i_status(status), .i_rd_data(rd_data), .o_rd_req(rd_req), .o_rd_opc(rd_opc),
    .o_rd_page(rd_page), .o_rd_off(rd_off), .o_wr_stb(wr_stb), .o_wr_data(wr_data),
    .o_wr_page(wr_page), .o_wr_off(wr_off), .o_prog_req(prog_req), .o_prog_opc(prog_opc));
  spi_host_model i_host (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so));
  function automatic logic [7:0] mem(logic [7:0] o, logic [8:0] p, logic [8:0] f);
    return o ^ p[7:0] ^ f[7:0] ^ {6'h0, p[8], f[8]};
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Fetched byte lands long before the slave needs it
  always @(negedge clk)
  begin
    cyc++;
    if (rd_req)
      rd_data <= mem(rd_opc, rd_page, rd_off);
    if (wr_stb)
      wr_log.push_back({wr_page, wr_off, wr_data});
    if (prog_req)
    begin
      n_prog++;
      last_opc = prog_opc;
    end
    if (cyc == 40000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic t_status(logic m3);
    @(negedge clk) status = 8'ha6;
    i_host.frame(m3, {`OPC_STATUS_READ, 120'h0}, 3, rx);
    check("status", 32'ha6a6, rx[15:0]);
  endtask
  task automatic t_id();
    i_host.frame(1'b1, {`OPC_ID_READ, 120'h0}, 5, rx);
    check("id", 32'h3c4d5e6f, rx[31:0]);
  endtask
  task automatic t_reads();
    logic [23:0] a;
    logic [8:0]  p1, f1;
    for (int i = 0; i < 8; i++)
    begin
      a  = (i < 4) ? 24'h01ffff : (i == 4) ? 24'h0000ff : 24'h0;
      p1 = (i < 3) ? 9'h0 : a[16:8];
      f1 = (i > 4) ? 9'h1 : 9'h0;
      i_host.frame(i[0], {OPCS[i], a, 96'h0}, 6 + DUM[i], rx);
      check("read", {mem(OPCS[i], a[16:8], {1'b0, a[7:0]}),
        mem(OPCS[i], p1, f1)}, rx[15:0]);
    end
  endtask
  task automatic t_264();
    @(negedge clk) p256 = 1'b0;
    i_host.frame(1'b1, {`OPC_PAGE_READ, 24'h02ab07, 96'h0}, 10, rx);
    check("read264", {mem(`OPC_PAGE_READ, 9'h155, 9'h107),
      mem(`OPC_PAGE_READ, 9'h155, 9'h0)}, rx[15:0]);
    t_status(1'b0);
    @(negedge clk) p256 = 1'b1;
  endtask
  task automatic t_write();
    i_host.frame(1'b0, {8'h82, 24'h0003fe, 24'h112233, 72'h0}, 7, rx);
    repeat (10) @(negedge clk);
    check("prog82", {8'h1, 8'h82}, {n_prog[7:0], last_opc});
    i_host.frame(1'b1, {8'h84, 24'h000010, 8'h77, 88'h0}, 5, rx);
    i_host.frame(1'b0, {8'h83, 24'h000500, 96'h0}, 4, rx);
    repeat (10) @(negedge clk);
    check("wr_cnt", 4, wr_log.size());
    for (int k = 0; k < 3; k++)
      check("wr", {9'h3, 1'b0, 8'hfe + 8'(k), 8'(17 * (k + 1))}, wr_log[k]);
    check("wr_buf", {9'h0, 9'h10, 8'h77}, wr_log[3]);
    check("prog83", {8'h2, 8'h83}, {n_prog[7:0], last_opc});
  endtask
  // Pointer page is rewritten after every program, far inside the wear span
  task automatic t_rewrite();
    logic [8:0] rw_ptr;
    rw_ptr = 9'h1fe;
    for (int k = 0; k < 2; k++)
    begin
      i_host.frame(1'b0, {8'h82, 7'h0, rw_ptr, 8'h00, 8'h5c, 88'h0}, 5, rx);
      repeat (10) @(negedge clk);
      check("rw_page", rw_ptr, wr_page);
      check("rw_opc", 8'h82, last_opc);
      rw_ptr = rw_ptr + 9'h1;
    end
  endtask
  task automatic t_pin();
    fork
      i_host.frame(1'b0, {`OPC_CARD_SLOW, 120'h0}, 6, rx);
      begin
        #4400 check("oe_rd", 0, oe_n);
        @(negedge clk) pin_n = 1'b0;
        repeat (6) @(negedge clk);
        check("oe_pin", 1, oe_n);
      end
    join
    @(negedge clk) pin_n = 1'b1;
    t_status(1'b1);
  endtask
  initial
  begin
    rst_n   = 1'b0;
    pin_n   = 1'b1;
    p256    = 1'b1;
    status  = 8'h0;
    rd_data = 8'h0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_status(1'b0);
    t_id();
    t_reads();
    t_264();
    t_write();
    t_rewrite();
    t_pin();
    summarize();
  end
endmodule
bind flash_spi_slave flash_spi_slave_asserts i_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_sck(i_sck),
  .i_reset_pin_n(i_reset_pin_n), .i_page_256(i_page_256), .o_so(o_so),
  .o_so_oe_n(o_so_oe_n), .o_rd_req(o_rd_req), .o_rd_opc(o_rd_opc),
  .o_rd_off(o_rd_off), .o_prog_req(o_prog_req));
`default_nettype wire
